// >>> hw/stream_record_cmd_timing.sv
// recording-control command timing and slot-mode logic
`timescale 1ns/1ps
module stream_record_cmd_timing #(
  parameter int CYC_PER_MS = rec_timing_pkg::MS_NS / rec_timing_pkg::CLK_NS,
  parameter int WIN = 8
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic link_clk,
  input wire logic cmd_strobe,
  input wire rec_timing_pkg::rec_cmd_t cmd_pins,
  input wire logic [3:0] iface_mode,
  input wire logic work_done,
  input wire logic wr_begin,
  input wire logic tw_start,
  input wire logic tw_end,
  input wire logic fs_rd_start,
  input wire logic fs_rd_end,
  input wire logic su_rd_start,
  input wire logic su_rd_end,
  input wire logic su_wr_start,
  input wire logic su_wr_end,
  input wire logic ru_access,
  output logic busy,
  output logic resp_error,
  output logic multi_slot,
  output logic guarantee_active
);
  import rec_timing_pkg::*;

  // ****************
  // link sampling
  // ****************
  logic [2:0] lclk_s_r;
  logic [1:0] stb_s_r;
  rec_cmd_t cmd_s1_r, cmd_s2_r;
  logic cmd_take;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lclk_s_r <= 3'h0;
      stb_s_r <= 2'h0;
      cmd_s1_r <= '0;
      cmd_s2_r <= '0;
    end else begin
      lclk_s_r <= {lclk_s_r[1:0], link_clk};
      stb_s_r <= {stb_s_r[0], cmd_strobe};
      cmd_s1_r <= cmd_pins;
      cmd_s2_r <= cmd_s1_r;
    end
  end
  // rising link edge with strobe high
  assign cmd_take = lclk_s_r[1] & ~lclk_s_r[2] & stb_s_r[1];

  // ****************
  // ms tick
  // ****************
  logic [16:0] pre_r;
  logic tick;
  assign tick = (pre_r == 17'(CYC_PER_MS - 1));
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pre_r <= 17'h0;
    end else begin
      pre_r <= tick ? 17'h0 : pre_r + 17'h1;
    end
  end

  // ****************
  // control register
  // ****************
  logic [10:0] ctrl_r;
  logic ext_cap;
  logic [2:0] class_sel;
  logic [6:0] modes_sup;
  logic wr_acc, rd_acc;
  assign ext_cap = ctrl_r[CTRL_EXT_BIT];
  assign class_sel = ctrl_r[CTRL_CLASS_LSB +: 3];
  assign modes_sup = ctrl_r[CTRL_MODES_LSB +: 7];
  assign wr_acc = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign rd_acc = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= CTRL_RESET;
    end else if (wr_acc && wb_adr_i == ADR_CTRL) begin
      if (wb_sel_i[0]) begin
        ctrl_r[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        ctrl_r[10:8] <= wb_dat_i[10:8];
      end
    end
  end

  // ****************
  // interface mode check
  // ****************
  logic [6:0] mand;
  logic [6:0] cur_bit;
  logic cfg_bad_now;
  assign guarantee_active = (iface_mode != IM_DS) && (iface_mode != IM_LOWEST_SDR_MODE);
  assign cur_bit = guarantee_active ? 7'(7'h01 << (iface_mode - IM_FIRST_FAST)) : 7'h00;
  always_comb begin
    mand = 7'h00;
    if (class_sel >= 3'h1) begin
      mand = mand | MM_HS;
    end
    if (class_sel >= 3'h3) begin
      mand = mand | MM_SDR50;
    end
    if (class_sel >= 3'h4) begin
      mand = mand | MM_FD;
    end
  end
  assign cfg_bad_now = (class_sel != 3'h0) &&
                       (((mand & ~modes_sup) != 7'h00) || ((cur_bit & ~modes_sup) != 7'h00));

  // ****************
  // command decode and slots
  // ****************
  logic [7:0] slots_r;
  logic multi_r;
  logic err_r;
  logic assoc_r;
  logic [9:0] assoc_lim_r;
  logic [9:0] busy_lim_r;
  logic fn_free_r;
  busy_st_t bst_r;
  logic [9:0] busy_ms_r;
  logic force_end, busy_end, start_cmd, start_wr;
  assign start_cmd = cmd_take;
  assign start_wr = wr_begin & assoc_r & (bst_r == ST_IDLE) & ~cmd_take;
  assign force_end = tick && (busy_ms_r + 10'h1 >= busy_lim_r);
  assign busy_end = (bst_r == ST_BUSY) && (work_done || force_end);

  function automatic logic [9:0] fn_limit(input logic [3:0] sc);
    logic [9:0] l;
    unique case (sc)
      SC_START: l = LIM_START_MS;
      SC_DIR: l = LIM_DIR_MS;
      SC_CI: l = LIM_CI_MS;
      SC_SUSP: l = LIM_SUSP_MS;
      SC_RESUME: l = LIM_RESUME_MS;
      SC_FREE: l = LIM_FREE_MS;
      SC_REL: l = LIM_REL_MS;
      default: l = LIM_DIR_MS;
    endcase
    return l;
  endfunction

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      slots_r <= 8'h00;
      multi_r <= 1'b0;
      err_r <= 1'b0;
    end else if (cmd_take) begin
      err_r <= 1'b0;
      unique case (cmd_s2_r.sub_command_code)
        SC_START: begin
          multi_r <= (slots_r[7:1] != 7'h00);
        end
        SC_DIR: begin
          if (slots_r[cmd_s2_r.slot_identifier_field]) begin
            err_r <= 1'b1;
          end else begin
            slots_r[cmd_s2_r.slot_identifier_field] <= 1'b1;
          end
        end
        SC_REL: slots_r[cmd_s2_r.slot_identifier_field] <= 1'b0;
        SC_SUSP: slots_r <= 8'h00;
        default: slots_r <= slots_r;
      endcase
    end
  end
  assign multi_slot = multi_r;
  assign resp_error = err_r;

  // associated write pending
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      assoc_r <= 1'b0;
      assoc_lim_r <= LIM_WR_HC_MS;
    end else if (cmd_take) begin
      assoc_r <= 1'b0;
      if (cmd_s2_r.sub_command_code == SC_DIR && !slots_r[cmd_s2_r.slot_identifier_field]) begin
        assoc_r <= 1'b1;
        assoc_lim_r <= ext_cap ? LIM_WR_XC_MS : LIM_WR_HC_MS;
      end else if (cmd_s2_r.sub_command_code == SC_CI) begin
        assoc_r <= 1'b1;
        assoc_lim_r <= LIM_WR_CI_MS;
      end
    end else if (start_wr) begin
      assoc_r <= 1'b0;
    end
  end

  // ****************
  // busy timer
  // ****************
  // busy counted in ms ticks
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bst_r <= ST_IDLE;
      busy_ms_r <= 10'h0;
      busy_lim_r <= LIM_DIR_MS;
      fn_free_r <= 1'b0;
    end else begin
      unique case (bst_r)
        ST_IDLE: begin
          if (start_cmd) begin
            bst_r <= ST_BUSY;
            busy_ms_r <= 10'h0;
            busy_lim_r <= fn_limit(cmd_s2_r.sub_command_code);
            fn_free_r <= (cmd_s2_r.sub_command_code == SC_FREE);
          end else if (start_wr) begin
            bst_r <= ST_BUSY;
            busy_ms_r <= 10'h0;
            busy_lim_r <= assoc_lim_r;
            fn_free_r <= 1'b0;
          end
        end
        ST_BUSY: begin
          if (busy_end) begin
            bst_r <= ST_IDLE;
            fn_free_r <= 1'b0;
          end else if (tick) begin
            busy_ms_r <= busy_ms_r + 10'h1;
          end
        end
      endcase
    end
  end
  assign busy = (bst_r == ST_BUSY);

  // ****************
  // table writes, sliding window
  // ****************
  logic tw_act_r;
  logic [9:0] tw_ms_r;
  logic [9:0] tw_hist_r [WIN];
  logic [WIN-1:0] tw_cap_r;
  logic [2:0] tw_idx_r;
  logic [12:0] tw_sum_r;
  logic [9:0] last_tw_r;
  logic tw_force, tw_fin, tw_hit_max;
  logic [3:0] ups_r;
  logic [3:0] open_cnt;
  logic [3:0] cap_cnt;
  logic [9:0] avg_ms;
  assign tw_force = tw_act_r && tick && (tw_ms_r + 10'h1 >= LIM_TW_MAX_MS);
  assign tw_fin = tw_act_r && (tw_end || tw_force);
  assign tw_hit_max = tw_force || (tw_ms_r >= LIM_TW_MAX_MS - 10'h1);
  assign avg_ms = tw_sum_r[12:3];
  always_comb begin
    open_cnt = 4'h0;
    cap_cnt = 4'h0;
    for (int i = 0; i < 8; i++) begin
      open_cnt = open_cnt + {3'h0, slots_r[i]};
    end
    for (int i = 0; i < WIN; i++) begin
      cap_cnt = cap_cnt + {3'h0, tw_cap_r[i]};
    end
  end
  // table write cut at 750 ms
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tw_act_r <= 1'b0;
      tw_ms_r <= 10'h0;
      last_tw_r <= 10'h0;
    end else if (tw_start && !tw_act_r) begin
      tw_act_r <= 1'b1;
      tw_ms_r <= 10'h0;
    end else if (tw_fin) begin
      tw_act_r <= 1'b0;
      last_tw_r <= tw_ms_r;
    end else if (tw_act_r && tick) begin
      tw_ms_r <= tw_ms_r + 10'h1;
    end
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tw_idx_r <= 3'h0;
      tw_sum_r <= 13'h0;
      tw_cap_r <= '0;
    end else if (tw_fin) begin
      tw_idx_r <= tw_idx_r + 3'h1;
      tw_sum_r <= tw_sum_r - {3'h0, tw_hist_r[tw_idx_r]} + {3'h0, tw_ms_r};
      tw_cap_r[tw_idx_r] <= tw_hit_max;
    end
  end
  generate
    for (genvar g = 0; g < WIN; g++) begin : g_hist
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          tw_hist_r[g] <= 10'h0;
        end else if (tw_fin && tw_idx_r == 3'(g)) begin
          tw_hist_r[g] <= tw_ms_r;
        end
      end
    end
  endgenerate
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ups_r <= 4'h0;
    end else if (ru_access) begin
      ups_r <= 4'h0;
    end else if (tw_fin && ups_r != 4'hf) begin
      ups_r <= ups_r + 4'h1;
    end
  end

  // ****************
  // read and write periods
  // ****************
  logic fs_act_r, su_rd_act_r, su_wr_act_r;
  logic [9:0] fs_ms_r;
  logic [15:0] rd_ms_r, wr_ms_r, worst_rd_r, worst_wr_r, pw_busy_r;
  // single 4KB read window from backend
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      fs_act_r <= 1'b0;
      fs_ms_r <= 10'h0;
    end else if (fs_rd_start) begin
      fs_act_r <= 1'b1;
      fs_ms_r <= 10'h0;
    end else if (fs_rd_end) begin
      fs_act_r <= 1'b0;
    end else if (fs_act_r && tick && fs_ms_r != 10'h3ff) begin
      fs_ms_r <= fs_ms_r + 10'h1;
    end
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      su_rd_act_r <= 1'b0;
      rd_ms_r <= 16'h0;
      worst_rd_r <= 16'h0;
    end else if (su_rd_start) begin
      su_rd_act_r <= 1'b1;
      rd_ms_r <= 16'h0;
    end else if (su_rd_end && su_rd_act_r) begin
      su_rd_act_r <= 1'b0;
      if (rd_ms_r > worst_rd_r) begin
        worst_rd_r <= rd_ms_r;
      end
    end else if (su_rd_act_r && tick) begin
      rd_ms_r <= rd_ms_r + 16'h1;
    end
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      su_wr_act_r <= 1'b0;
      wr_ms_r <= 16'h0;
      worst_wr_r <= 16'h0;
      pw_busy_r <= 16'h0;
    end else begin
      if (su_wr_start) begin
        su_wr_act_r <= 1'b1;
      end else if (su_wr_end && su_wr_act_r) begin
        su_wr_act_r <= 1'b0;
        wr_ms_r <= 16'h0;
        if (wr_ms_r > worst_wr_r) begin
          worst_wr_r <= wr_ms_r;
        end
      end else if (tick && (su_wr_act_r || (busy && fn_free_r))) begin
        wr_ms_r <= wr_ms_r + 16'h1;
      end
      if (tick && busy && fn_free_r) begin
        pw_busy_r <= pw_busy_r + 16'h1;
      end
    end
  end

  // ****************
  // sticky flags
  // ****************
  flags_t flg_r, flg_set;
  logic flg_clr_en;
  always_comb begin
    flg_set = '0;
    flg_set.busy_over = busy_end && force_end && !work_done;
    flg_set.tw_over = tw_force && guarantee_active;
    flg_set.avg_over = guarantee_active &&
                       (avg_ms > (multi_r ? LIM_AVG_MULTI_MS : LIM_AVG_SINGLE_MS));
    flg_set.max_twice = guarantee_active && (cap_cnt > 4'h1);
    flg_set.fs_slow = guarantee_active && fs_act_r && (fs_ms_r >= LIM_FS_RD_MS);
    flg_set.pr_low = guarantee_active && (worst_wr_r != 16'h0) && (worst_rd_r > worst_wr_r);
    flg_set.slot_over = guarantee_active &&
                        (ups_r > ((open_cnt == 4'h0) ? 4'h1 : open_cnt));
    flg_set.cfg_bad = cfg_bad_now;
  end
  assign flg_clr_en = wr_acc && (wb_adr_i == ADR_FLAGS) && wb_sel_i[0];
  // set wins over clear
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      flg_r <= '0;
    end else if (flg_clr_en) begin
      flg_r <= (flg_r & ~flags_t'(wb_dat_i[7:0])) | flg_set;
    end else begin
      flg_r <= flg_r | flg_set;
    end
  end

  // ****************
  // wishbone read and ack
  // ****************
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (rd_acc) begin
        unique case (wb_adr_i)
          ADR_CTRL: wb_dat_o <= {21'h0, ctrl_r};
          ADR_STATUS: wb_dat_o <= {16'h0, ups_r, guarantee_active, assoc_r, busy,
                                   multi_r, slots_r};
          ADR_FLAGS: wb_dat_o <= {24'h0, flg_r};
          ADR_TWTIME: wb_dat_o <= {6'h0, last_tw_r, 6'h0, avg_ms};
          ADR_PWBUSY: wb_dat_o <= {16'h0, pw_busy_r};
          ADR_WORST: wb_dat_o <= {worst_rd_r, worst_wr_r};
          default: wb_dat_o <= 32'h0;
        endcase
      end
    end
  end
endmodule

// >>> inc/rec_timing_pkg.sv
// constants and types for the recording-control timing block
package rec_timing_pkg;
  // ****************
  // register map
  // ****************
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_FLAGS = 8'h08;
  localparam logic [7:0] ADR_TWTIME = 8'h0c;
  localparam logic [7:0] ADR_PWBUSY = 8'h10;
  localparam logic [7:0] ADR_WORST = 8'h14;
  localparam int CTRL_EXT_BIT = 0;
  localparam int CTRL_CLASS_LSB = 1;
  localparam int CTRL_MODES_LSB = 4;
  localparam logic [10:0] CTRL_RESET = 11'h000;
  // ****************
  // timing in ms, clock constants in ns
  // ****************
  localparam int MS_NS = 1000000;
  localparam int CLK_NS = 25;
  localparam logic [9:0] LIM_START_MS = 10'h3e8;
  localparam logic [9:0] LIM_DIR_MS = 10'h00a;
  localparam logic [9:0] LIM_CI_MS = 10'h00a;
  localparam logic [9:0] LIM_SUSP_MS = 10'h0fa;
  localparam logic [9:0] LIM_RESUME_MS = 10'h0fa;
  localparam logic [9:0] LIM_FREE_MS = 10'h0fa;
  localparam logic [9:0] LIM_REL_MS = 10'h032;
  localparam logic [9:0] LIM_WR_HC_MS = 10'h0fa;
  localparam logic [9:0] LIM_WR_XC_MS = 10'h1f4;
  localparam logic [9:0] LIM_WR_CI_MS = 10'h0fa;
  localparam logic [9:0] LIM_FS_RD_MS = 10'h014;
  localparam logic [9:0] LIM_TW_MAX_MS = 10'h2ee;
  localparam logic [9:0] LIM_AVG_SINGLE_MS = 10'h064;
  localparam logic [9:0] LIM_AVG_MULTI_MS = 10'h096;
  // ****************
  // sub-command codes
  // ****************
  localparam logic [3:0] SC_START = 4'h0;
  localparam logic [3:0] SC_DIR = 4'h1;
  localparam logic [3:0] SC_CI = 4'h4;
  localparam logic [3:0] SC_SUSP = 4'h5;
  localparam logic [3:0] SC_RESUME = 4'h6;
  localparam logic [3:0] SC_FREE = 4'h7;
  localparam logic [3:0] SC_REL = 4'h8;
  // ****************
  // interface modes
  // ****************
  localparam logic [3:0] IM_DS = 4'h0;
  localparam logic [3:0] IM_LOWEST_SDR_MODE = 4'h1;
  localparam logic [3:0] IM_FIRST_FAST = 4'h2;
  localparam logic [6:0] MM_HS = 7'h01;
  localparam logic [6:0] MM_SDR50 = 7'h04;
  localparam logic [6:0] MM_FD = 7'h20;

  typedef struct packed {
    logic [3:0] sub_command_code;
    logic [2:0] slot_identifier_field;
  } rec_cmd_t;

  typedef struct packed {
    logic cfg_bad;
    logic slot_over;
    logic pr_low;
    logic fs_slow;
    logic max_twice;
    logic avg_over;
    logic tw_over;
    logic busy_over;
  } flags_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } busy_st_t;
endpackage

// >>> verif/stream_record_cmd_timing_sva.sv
// port-level assertions for the recording-control timing block
`timescale 1ns/1ps
module rec_timing_sva #(
  parameter int CYC_PER_MS = 40000
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic cmd_strobe,
  input wire rec_timing_pkg::rec_cmd_t cmd_pins,
  input wire logic [3:0] iface_mode,
  input wire logic work_done,
  input wire logic wr_begin,
  input wire logic busy,
  input wire logic resp_error,
  input wire logic multi_slot,
  input wire logic guarantee_active
);
  import rec_timing_pkg::*;
  logic busy_q;
  logic [31:0] busy_cnt;
  logic [31:0] lim_cyc;
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  function automatic logic [9:0] lim_of(input logic [3:0] c);
    case (c)
      SC_START: lim_of = LIM_START_MS;
      SC_DIR, SC_CI: lim_of = LIM_DIR_MS;
      SC_REL: lim_of = LIM_REL_MS;
      default: lim_of = LIM_FREE_MS;
    endcase
  endfunction
  // ****************
  // busy length tracking
  // ****************
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      busy_q <= 1'b0;
      busy_cnt <= 32'h0;
    end else begin
      busy_q <= busy;
      busy_cnt <= busy ? busy_cnt + 32'h1 : 32'h0;
    end
  end
  // limit of the job that just began; a write job gets the longest write limit
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lim_cyc <= 32'h0;
    end else if (busy && !busy_q) begin
      lim_cyc <= (cmd_strobe ? 32'(lim_of(cmd_pins.sub_command_code)) :
        32'(LIM_WR_XC_MS)) * CYC_PER_MS;
    end
  end
  // ****************
  // assertions
  // ****************
  ack_one_shot_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  guar_mode_a: assert property (
    iface_mode <= 4'h8 |-> guarantee_active == (iface_mode >= IM_FIRST_FAST))
    else $error("guarantee flag wrong for mode");
  busy_bound_a: assert property (busy_cnt <= lim_cyc + 32'h2)
    else $error("busy beyond function limit");
  busy_end_a: assert property (busy && work_done |=> !busy)
    else $error("busy not ended by work done");
  mode_change_a: assert property (
    $changed(multi_slot) |-> $rose(busy) && cmd_strobe &&
    cmd_pins.sub_command_code == SC_START)
    else $error("slot mode changed outside start");
  err_cause_a: assert property (
    $rose(resp_error) |-> cmd_strobe && cmd_pins.sub_command_code == SC_DIR)
    else $error("error raised without directory update");
  busy_cause_a: assert property (
    $rose(busy) |-> cmd_strobe || $past(wr_begin) || $past(wr_begin, 2))
    else $error("busy without command or write");
  multi_cov: cover property ($rose(multi_slot));
  err_cov: cover property ($rose(resp_error));
  limit_cov: cover property (busy && busy_cnt + 32'h40 > lim_cyc);
endmodule

// >>> verif/host_link_model.sv
// host side of the card bus: issues recording-control commands
`timescale 1ns/1ps
module host_link_model (
  output logic link_clk,
  output logic cmd_strobe,
  output rec_timing_pkg::rec_cmd_t cmd_pins
);
  import rec_timing_pkg::*;
  initial begin
    link_clk = 1'b0;
    cmd_strobe = 1'b0;
    cmd_pins = 7'h7f;
  end
  // control function frame
  // one link rise per frame; clock idle and pins inverted outside frames
  task automatic send(input rec_cmd_t c);
    cmd_pins = c;
    cmd_strobe = 1'b1;
    #100 link_clk = 1'b1;
    #100 link_clk = 1'b0;
    #100 cmd_strobe = 1'b0;
    cmd_pins = ~c;
  endtask
endmodule

// >>> verif/tb_stream_record_cmd_timing.sv
// self-checking bench for the recording-control timing block
`timescale 1ns/1ps
module tb_stream_record_cmd_timing;
  import rec_timing_pkg::*;
  localparam int C = 40;
  localparam int LIMIT = 95000;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_we_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic link_clk;
  logic cmd_strobe;
  rec_cmd_t cmd_pins;
  logic [3:0] iface_mode = 4'h0;
  logic [10:0] ev = 11'h000;
  logic busy, resp_error, multi_slot, guarantee_active;
  logic [31:0] q;
  logic [31:0] pw0;
  logic [3:0] code [7] = '{SC_START, SC_DIR, SC_CI, SC_SUSP, SC_RESUME, SC_FREE, SC_REL};
  logic [9:0] lim [7] = '{LIM_START_MS, LIM_DIR_MS, LIM_CI_MS, LIM_SUSP_MS, LIM_RESUME_MS,
    LIM_FREE_MS, LIM_REL_MS};
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int n;
  always #12.5 clk_sys = ~clk_sys;
  stream_record_cmd_timing #(.CYC_PER_MS(C)) i_dut (
    .clk_sys(clk_sys), .rstn(rstn), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .link_clk(link_clk),
    .cmd_strobe(cmd_strobe), .cmd_pins(cmd_pins), .iface_mode(iface_mode),
    .work_done(ev[0]), .wr_begin(ev[1]), .tw_start(ev[2]), .tw_end(ev[3]),
    .fs_rd_start(ev[4]), .fs_rd_end(ev[5]), .su_rd_start(ev[7]), .su_rd_end(ev[8]),
    .su_wr_start(ev[9]), .su_wr_end(ev[10]), .ru_access(ev[6]), .busy(busy),
    .resp_error(resp_error), .multi_slot(multi_slot), .guarantee_active(guarantee_active));
  host_link_model i_host (.link_clk(link_clk), .cmd_strobe(cmd_strobe), .cmd_pins(cmd_pins));
  // ****************
  // tasks
  // ****************
  task automatic tally_and_finish;
    if (err_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic rng(input logic [31:0] g, input int lo, input int hi);
    n_tests++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %0d want %0d..%0d", $time, g, lo, hi);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    @(posedge clk_sys);
    while (wb_ack_o !== 1'b1) @(posedge clk_sys);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    cmp(q & m, e);
  endtask
  task automatic pulse(input int i);
    ev[i] <= 1'b1;
    @(posedge clk_sys);
    ev <= '0;
    @(posedge clk_sys);
  endtask
  // start pulse, ms of activity, end pulse
  task automatic timed(input int s, input int ms);
    pulse(s);
    repeat (ms * C - 2) @(posedge clk_sys);
    pulse(s + 1);
  endtask
  task automatic cmd(input logic [3:0] c, input logic [2:0] s);
    i_host.send({c, s});
    @(posedge clk_sys);
    pulse(0);
    while (busy !== 1'b0) @(posedge clk_sys);
  endtask
  // ****************
  // watchdog
  // ****************
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == LIMIT) begin
      err_count++;
      tally_and_finish;
    end
  end
  // ****************
  // main sequence
  // ****************
  initial begin
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    cmp({30'h0, multi_slot, busy}, 32'h0);
    rdc(ADR_CTRL, 32'h7ff, 32'h0);
    rdc(8'h20, 32'hffffffff, 32'h0);
    for (int m = 0; m < 9; m++) begin
      iface_mode <= 4'(m);
      repeat (2) @(posedge clk_sys);
      cmp(32'(guarantee_active), 32'(m > 1));
    end
    iface_mode <= IM_FIRST_FAST;
    wb(1'b1, ADR_CTRL, 32'h002);
    rdc(ADR_FLAGS, 32'h80, 32'h80);
    wb(1'b1, ADR_CTRL, 32'h012);
    wb(1'b1, ADR_FLAGS, 32'hff);
    rdc(ADR_FLAGS, 32'h80, 32'h0);
    rdc(ADR_CTRL, 32'h7ff, 32'h012);
    cmd(SC_START, 3'h0);
    cmp(32'(multi_slot), 32'h0);
    cmd(SC_DIR, 3'h0);
    rdc(ADR_STATUS, 32'h4ff, 32'h401);
    pulse(1);
    repeat (2) @(posedge clk_sys);
    cmp(32'(busy), 32'h1);
    pulse(0);
    rdc(ADR_STATUS, 32'h600, 32'h0);
    cmd(SC_START, 3'h0);
    cmp(32'(multi_slot), 32'h0);
    cmd(SC_DIR, 3'h0);
    cmp(32'(resp_error), 32'h1);
    cmd(SC_DIR, 3'h3);
    cmp({30'h0, resp_error, multi_slot}, 32'h0);
    cmd(SC_START, 3'h0);
    cmp(32'(multi_slot), 32'h1);
    wb(1'b1, ADR_FLAGS, 32'hff);
    timed(4, 5);
    rdc(ADR_FLAGS, 32'h10, 32'h0);
    timed(4, 25);
    rdc(ADR_FLAGS, 32'h10, 32'h10);
    timed(2, 20);
    wb(1'b0, ADR_TWTIME, 32'h0);
    rng(32'(q[25:16]), 19, 20);
    cmp(32'(q[9:0]), 32'h2);
    rdc(ADR_STATUS, 32'hf000, 32'h1000);
    pulse(6);
    rdc(ADR_STATUS, 32'hf000, 32'h0);
    timed(9, 4);
    rdc(ADR_FLAGS, 32'h20, 32'h0);
    timed(7, 6);
    rdc(ADR_FLAGS, 32'h20, 32'h20);
    wb(1'b0, ADR_WORST, 32'h0);
    rng(32'(q[31:16]), 5, 6);
    rng(32'(q[15:0]), 3, 4);
    for (int k = 0; k < 7; k++) begin
      wb(1'b0, ADR_PWBUSY, 32'h0);
      pw0 = q;
      i_host.send({code[k], 3'h5});
      n = 0;
      while (busy !== 1'b0) begin
        @(posedge clk_sys);
        n++;
      end
      rng(32'(n), (lim[k] - 1) * C - 12, lim[k] * C);
      wb(1'b0, ADR_PWBUSY, 32'h0);
      rng(q - pw0, code[k] == SC_FREE ? 249 : 0, code[k] == SC_FREE ? 250 : 0);
    end
    tally_and_finish;
  end
endmodule
bind stream_record_cmd_timing rec_timing_sva #(.CYC_PER_MS(CYC_PER_MS)) i_sva (
  .clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .cmd_strobe(cmd_strobe), .cmd_pins(cmd_pins),
  .iface_mode(iface_mode), .work_done(work_done), .wr_begin(wr_begin), .busy(busy),
  .resp_error(resp_error), .multi_slot(multi_slot), .guarantee_active(guarantee_active));
